/* File: design/fsc_port_map.vh */
// Constant map for the fault, status and CRC serial port of the current driver.
// Assumes a 16-bit or 24-bit serial frame framed by an active-low strobe.
//
// Contract
// RULE_01 - Matching address with read bit requests readback.
// RULE_02 - Data out tristated; drives from fifth rising edge.
// RULE_03 - Data out released at next strobe rising edge.
// RULE_04 - Readback word: address, 1, 0, config, flags.
// RULE_05 - Read frame still applies its configuration bits.
// RULE_06 - Three fault flags pull shared alarm low.
// RULE_07 - Strap pin selects pin-configured range mode.
// RULE_08 - Strap mode: no status, two separate alarms.
// RULE_09 - Software alarm: open loop, CRC fail, overheat.
// RULE_10 - Overheat detector sets overheat flag and alarm.
// RULE_11 - Low headroom sets open-loop flag and alarm.
// RULE_12 - CRC check failure sets CRC error flag.
// RULE_13 - Clear input forces clear level while high.
// RULE_14 - Clear level is pin OR shifted bit.
// RULE_15 - Level 0 bottom of range, 1 midscale.
// RULE_16 - Clear command bit also clears the output.
// RULE_17 - Resistor-select bit picks internal or external.
// RULE_18 - Four-bit range code from bits or pins.
// RULE_19 - Host appends CRC-8 and sends 24 bits.
// RULE_20 - 24-bit frame checked at strobe rise.
// RULE_21 - Status readback clears CRC flag, releases alarm.
// RULE_22 - Input bits sampled on falling serial edge.
// RULE_23 - Output stays off until output-on bit set; strap mode turns the output on without it.
// RULE_24 - Software clear bit is active high.
// RULE_25 - CRC MSB first from zero; odd lengths ignored.
`ifndef FSC_PORT_MAP_VH
`define FSC_PORT_MAP_VH

// Frame lengths and counter widths.
`define FSC_CNT_W 5
`define FSC_FRAME_PLAIN 5'h10
`define FSC_FRAME_CRC 5'h18
`define FSC_HDR_BITS 5'h04
`define FSC_READ_START_EDGE 5'h05
`define FSC_READ_BITS 5'h10
`define FSC_CNT_ONE 5'h01
`define FSC_CNT_MAX 5'h1f

// Write frame field positions.
`define FSC_ADDR_HI 15
`define FSC_ADDR_LO 13
`define FSC_RW_BIT 12
`define FSC_RANGE_HI 10
`define FSC_RANGE_LO 7
`define FSC_CLEAR_LEVEL_SEL_BIT 6
`define FSC_OUTPUT_ON_BIT 5
`define FSC_SENSE_RES_SEL_BIT 4
`define FSC_SWCLR_BIT 3
`define FSC_SWRST_BIT 2

// Address and CRC fields inside the frame shift register.
`define FSC_HDR_ADDR_HI 3
`define FSC_HDR_ADDR_LO 1
`define FSC_HDR_RW 0
`define FSC_CRC_HI 7
`define FSC_CRC_LO 0

// Fixed bits and unused bit of the readback word.
`define FSC_STAT_ONE 1'h1
`define FSC_STAT_ZERO 1'h0
`define FSC_STAT_UNUSED 1'h0

// Reset values of the configuration held from serial frames.
`define FSC_RANGE_RST 4'h0
`define FSC_CLEAR_LEVEL_SEL_RST 1'h0
`define FSC_OUTPUT_ON_RST 1'h0
`define FSC_SENSE_RES_SEL_RST 1'h0
`define FSC_SWCLR_RST 1'h0

// CRC-8 generator x^8 + x^2 + x + 1 and its start value.
`define FSC_CRC_POLY 8'h07
`define FSC_CRC_INIT 8'h00

`endif

/* File: design/fsc_edge_detect.v */
// Edge detector for one synchronous input level.
// Assumes the input is already synchronous to the clock.
`timescale 1ns/100ps
`default_nettype none

module fsc_edge_detect (
  input wire clk,
  input wire rstn,
  input wire sigIn,
  input wire resetLevel,
  output reg sigLvl_reg,
  output reg risePulse_reg,
  output reg fallPulse_reg
);

  // Registers the level and flags one-cycle rising and falling pulses.
  always @(posedge clk) begin
    if (!rstn) begin
      sigLvl_reg <= resetLevel;
      risePulse_reg <= 1'b0;
      fallPulse_reg <= 1'b0;
    end else begin
      sigLvl_reg <= sigIn;
      risePulse_reg <= sigIn & ~sigLvl_reg;
      fallPulse_reg <= ~sigIn & sigLvl_reg;
    end
  end

endmodule // fsc_edge_detect

`default_nettype wire

/* File: design/fsc_crc8.v */
// Serial CRC-8 accumulator, most significant bit first.
// Assumes one data bit per enable pulse and a clear at frame start.
`timescale 1ns/100ps
`default_nettype none
`include "fsc_port_map.vh"

module fsc_crc8 (
  input wire clk,
  input wire rstn,
  input wire crcClear,
  input wire crcEnable,
  input wire dataBit,
  output reg [7:0] crc_reg
);

  wire feedback;
  wire [7:0] crcShifted;

  // Feedback term and shifted register for the next step.
  assign feedback = crc_reg[7] ^ dataBit;
  assign crcShifted = {crc_reg[6:0], 1'b0};

  // Clears at frame start, then folds in one bit per enable.
  always @(posedge clk) begin
    if (!rstn || crcClear) begin
      crc_reg <= `FSC_CRC_INIT; // RULE_25
    end else if (crcEnable) begin
      crc_reg <= feedback ? (crcShifted ^ `FSC_CRC_POLY) : crcShifted; // RULE_25
    end
  end

endmodule // fsc_crc8

`default_nettype wire

/* File: design/fsc_serial_port.v */
// Serial control, status readback and fault alarm logic of the current driver.
// Assumes serial clock, data, strobe and detector inputs are synchronous to ref_clk
// and that each serial clock phase lasts at least three ref_clk cycles.
`timescale 1ns/100ps
`default_nettype none
`include "fsc_port_map.vh"

module fsc_serial_port (
  input wire ref_clk,
  input wire rstn,
  input wire serialClk,
  input wire serialDataIn,
  input wire frameSyncN,
  input wire [2:0] deviceAddrBits,
  input wire pinStrapModeSel,
  input wire [3:0] rangeCodePins,
  input wire senseResSelPin,
  input wire clearLevelSelPin,
  input wire clearIn,
  input wire overTempDetect,
  input wire headroomLowDetect,
  output reg serialDataOut_reg,
  output reg serialDataOutOe_reg,
  output reg faultAlarmOut_reg,
  output reg faultAlarmOe_reg,
  output reg openLoopAlarmNOut_reg,
  output reg openLoopAlarmNOe_reg,
  output reg overheatAlarmNOut_reg,
  output reg overheatAlarmNOe_reg,
  output reg [3:0] rangeCode_reg,
  output reg senseResSel_reg,
  output reg outputOn_reg,
  output reg clearActive_reg,
  output reg clearToMid_reg
);

  // Edge detector and CRC outputs.
  wire sclkLvl;
  wire sclkRise;
  wire sclkFall;
  wire syncLvl;
  wire syncRise;
  wire syncFall;
  wire [7:0] crcValue;

  // Frame state.
  reg sdinDly_reg;
  reg [23:0] frameShift_reg;
  reg [`FSC_CNT_W-1:0] fallCnt_reg;
  reg [`FSC_CNT_W-1:0] riseCnt_reg;
  reg [`FSC_CNT_W-1:0] outCnt_reg;
  reg readReq_reg;
  reg [15:0] readShift_reg;

  // Strap mode latched at reset and configuration held from serial frames.
  reg pinMode_reg;
  reg [3:0] cfgRange_reg;
  reg cfgClearSel_reg;
  reg cfgOutputOn_reg;
  reg cfgSenseRes_reg;
  reg cfgSwClear_reg;

  // Fault flags.
  reg crcErrFlag_reg;
  reg overheatFlag_reg;
  reg loopOpenFlag_reg;

  // Frame end decode.
  reg [15:0] frameWord;
  reg frameAddrHit;
  reg frameAccept;
  reg crcFail;
  reg readDone;
  wire [15:0] statusWord;
  wire frameActive;
  wire readStart;

  // Serial clock edges; the pin is treated as a plain synchronous input.
  fsc_edge_detect sclkEdge (
    .clk(ref_clk),
    .rstn(rstn),
    .sigIn(serialClk),
    .resetLevel(1'b1),
    .sigLvl_reg(sclkLvl),
    .risePulse_reg(sclkRise),
    .fallPulse_reg(sclkFall)
  );

  // Frame strobe edges.
  fsc_edge_detect syncEdge (
    .clk(ref_clk),
    .rstn(rstn),
    .sigIn(frameSyncN),
    .resetLevel(1'b1),
    .sigLvl_reg(syncLvl),
    .risePulse_reg(syncRise),
    .fallPulse_reg(syncFall)
  );

  // CRC over the first sixteen received bits only.
  fsc_crc8 frameCrc (
    .clk(ref_clk),
    .rstn(rstn),
    .crcClear(syncFall),
    .crcEnable(sclkFall & frameActive & (fallCnt_reg < `FSC_FRAME_PLAIN)),
    .dataBit(sdinDly_reg),
    .crc_reg(crcValue)
  );

  assign frameActive = ~syncLvl;

  // Readback word: address, fixed 1 and 0, configuration, then the flags.
  assign statusWord = {deviceAddrBits, `FSC_STAT_ONE, `FSC_STAT_ZERO, cfgRange_reg,
                       cfgClearSel_reg, cfgOutputOn_reg, cfgSenseRes_reg,
                       crcErrFlag_reg, overheatFlag_reg, loopOpenFlag_reg,
                       `FSC_STAT_UNUSED}; // RULE_04

  // First readback bit goes out on the fifth rising serial edge.
  assign readStart = sclkRise & frameActive & readReq_reg &
                     (riseCnt_reg >= (`FSC_READ_START_EDGE - `FSC_CNT_ONE)); // RULE_02

  // Decodes the frame at the strobe rising edge.
  always @* begin
    frameWord = (fallCnt_reg == `FSC_FRAME_CRC) ? frameShift_reg[23:8] : frameShift_reg[15:0];
    frameAddrHit = (frameWord[`FSC_ADDR_HI:`FSC_ADDR_LO] == deviceAddrBits);
    crcFail = (fallCnt_reg == `FSC_FRAME_CRC) &&
              (frameShift_reg[`FSC_CRC_HI:`FSC_CRC_LO] != crcValue); // RULE_20
    frameAccept = syncRise && !pinMode_reg && frameAddrHit &&
                  ((fallCnt_reg == `FSC_FRAME_PLAIN) ||
                   ((fallCnt_reg == `FSC_FRAME_CRC) && !crcFail)); // RULE_25
    readDone = syncRise && readReq_reg && (outCnt_reg == `FSC_READ_BITS);
  end

  // Samples serial data alongside the delayed serial clock level.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      sdinDly_reg <= 1'b0;
    end else begin
      sdinDly_reg <= serialDataIn;
    end
  end

  // Shifts in one bit on each falling serial edge inside a frame.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      frameShift_reg <= 24'h000000;
      fallCnt_reg <= {`FSC_CNT_W{1'b0}};
    end else if (syncFall) begin
      fallCnt_reg <= {`FSC_CNT_W{1'b0}};
    end else if (sclkFall && frameActive) begin
      frameShift_reg <= {frameShift_reg[22:0], sdinDly_reg}; // RULE_22
      if (fallCnt_reg != `FSC_CNT_MAX) begin
        fallCnt_reg <= fallCnt_reg + `FSC_CNT_ONE;
      end
    end
  end

  // Counts rising serial edges within the frame.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      riseCnt_reg <= {`FSC_CNT_W{1'b0}};
    end else if (syncFall) begin
      riseCnt_reg <= {`FSC_CNT_W{1'b0}};
    end else if (sclkRise && frameActive && riseCnt_reg != `FSC_CNT_MAX) begin
      riseCnt_reg <= riseCnt_reg + `FSC_CNT_ONE;
    end
  end

  // Flags a read once address and read bit have arrived.
  always @(posedge ref_clk) begin
    if (!rstn || syncFall || syncRise) begin
      readReq_reg <= 1'b0;
    end else if (frameActive && !pinMode_reg && fallCnt_reg == `FSC_HDR_BITS &&
                 frameShift_reg[`FSC_HDR_ADDR_HI:`FSC_HDR_ADDR_LO] == deviceAddrBits &&
                 frameShift_reg[`FSC_HDR_RW]) begin
      readReq_reg <= 1'b1; // RULE_01
    end
  end

  // Drives readback bits out, then releases the pin at the strobe rise.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      serialDataOut_reg <= 1'b0;
      serialDataOutOe_reg <= 1'b0;
      readShift_reg <= 16'h0000;
      outCnt_reg <= {`FSC_CNT_W{1'b0}};
    end else if (syncRise || syncFall) begin
      serialDataOutOe_reg <= 1'b0; // RULE_03
      outCnt_reg <= {`FSC_CNT_W{1'b0}};
    end else if (readStart && outCnt_reg < `FSC_READ_BITS) begin
      serialDataOutOe_reg <= 1'b1; // RULE_02
      outCnt_reg <= outCnt_reg + `FSC_CNT_ONE;
      if (outCnt_reg == {`FSC_CNT_W{1'b0}}) begin
        serialDataOut_reg <= statusWord[15];
        readShift_reg <= {statusWord[14:0], 1'b0};
      end else begin
        serialDataOut_reg <= readShift_reg[15];
        readShift_reg <= {readShift_reg[14:0], 1'b0};
      end
    end
  end

  // Latches the strap pin while reset is held.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      pinMode_reg <= pinStrapModeSel; // RULE_07
    end
  end

  // Applies configuration from accepted frames, read frames included.
  always @(posedge ref_clk) begin
    if (!rstn || (frameAccept && frameWord[`FSC_SWRST_BIT])) begin
      cfgRange_reg <= `FSC_RANGE_RST;
      cfgClearSel_reg <= `FSC_CLEAR_LEVEL_SEL_RST;
      cfgOutputOn_reg <= `FSC_OUTPUT_ON_RST;
      cfgSenseRes_reg <= `FSC_SENSE_RES_SEL_RST;
      cfgSwClear_reg <= `FSC_SWCLR_RST;
    end else if (frameAccept) begin
      cfgRange_reg <= frameWord[`FSC_RANGE_HI:`FSC_RANGE_LO]; // RULE_05
      cfgClearSel_reg <= frameWord[`FSC_CLEAR_LEVEL_SEL_BIT];
      cfgOutputOn_reg <= frameWord[`FSC_OUTPUT_ON_BIT];
      cfgSenseRes_reg <= frameWord[`FSC_SENSE_RES_SEL_BIT];
      cfgSwClear_reg <= frameWord[`FSC_SWCLR_BIT];
    end
  end

  // CRC error flag; a failure in the clearing cycle wins over the clear.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      crcErrFlag_reg <= 1'b0;
    end else if (syncRise && !pinMode_reg && crcFail && frameAddrHit) begin
      crcErrFlag_reg <= 1'b1; // RULE_12
    end else if (readDone) begin
      crcErrFlag_reg <= 1'b0; // RULE_21
    end
  end

  // Live fault flags follow the analog detectors.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      overheatFlag_reg <= 1'b0;
      loopOpenFlag_reg <= 1'b0;
    end else begin
      overheatFlag_reg <= overTempDetect; // RULE_10
      loopOpenFlag_reg <= headroomLowDetect; // RULE_11
    end
  end

  // Open-drain alarms; each output value is low and only its enable moves.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      faultAlarmOut_reg <= 1'b0;
      faultAlarmOe_reg <= 1'b0;
      openLoopAlarmNOut_reg <= 1'b0;
      openLoopAlarmNOe_reg <= 1'b0;
      overheatAlarmNOut_reg <= 1'b0;
      overheatAlarmNOe_reg <= 1'b0;
    end else begin
      faultAlarmOut_reg <= 1'b0;
      openLoopAlarmNOut_reg <= 1'b0;
      overheatAlarmNOut_reg <= 1'b0;
      faultAlarmOe_reg <= !pinMode_reg &&
                          (crcErrFlag_reg || overheatFlag_reg || loopOpenFlag_reg); // RULE_06 RULE_09
      openLoopAlarmNOe_reg <= pinMode_reg && loopOpenFlag_reg; // RULE_08
      overheatAlarmNOe_reg <= pinMode_reg && overheatFlag_reg; // RULE_08
    end
  end

  // Output controls for the analog stage.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      rangeCode_reg <= `FSC_RANGE_RST;
      senseResSel_reg <= `FSC_SENSE_RES_SEL_RST;
      outputOn_reg <= `FSC_OUTPUT_ON_RST;
      clearActive_reg <= 1'b0;
      clearToMid_reg <= 1'b0;
    end else begin
      rangeCode_reg <= pinMode_reg ? rangeCodePins : cfgRange_reg; // RULE_18
      senseResSel_reg <= pinMode_reg ? senseResSelPin : cfgSenseRes_reg; // RULE_17
      outputOn_reg <= pinMode_reg | cfgOutputOn_reg; // RULE_23
      clearActive_reg <= clearIn | (!pinMode_reg & cfgSwClear_reg); // RULE_13 RULE_16 RULE_24
      clearToMid_reg <= clearLevelSelPin | (!pinMode_reg & cfgClearSel_reg); // RULE_14 RULE_15
    end
  end

endmodule // fsc_serial_port

`default_nettype wire

/* File: tb/fsc_serial_port_chk.sv */
// Concurrent checks on the ports of the fault, status and CRC serial port.
// Assumes serial phases of at least three ref_clk cycles and one clock domain.
`timescale 1ns/100ps
`default_nettype none

module fsc_serial_port_chk (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic frameSyncN,
  input wire logic clearIn,
  input wire logic clearLevelSelPin,
  input wire logic overTempDetect,
  input wire logic headroomLowDetect,
  input wire logic serialDataOutOe_reg,
  input wire logic faultAlarmOut_reg,
  input wire logic faultAlarmOe_reg,
  input wire logic openLoopAlarmNOe_reg,
  input wire logic overheatAlarmNOe_reg,
  input wire logic [3:0] rangeCode_reg,
  input wire logic outputOn_reg,
  input wire logic clearActive_reg,
  input wire logic clearToMid_reg
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // Levels held long enough to cross the input sampling and output registers.
  sequence heatHeld; overTempDetect[*4]; endsequence
  sequence loopHeld; headroomLowDetect[*4]; endsequence
  sequence strobeIdle; frameSyncN[*5]; endsequence
  sequence frameLong; !frameSyncN[*6]; endsequence

  chk_sdo_idle: assert property (strobeIdle |-> !serialDataOutOe_reg)
    else $error("data out driven between frames");
  chk_sdo_frame: assert property ($rose(serialDataOutOe_reg) |-> !frameSyncN)
    else $error("data out enabled outside a frame");
  chk_loop_alarm: assert property (loopHeld |-> faultAlarmOe_reg || openLoopAlarmNOe_reg)
    else $error("open loop not alarmed");
  chk_heat_alarm: assert property (heatHeld |-> faultAlarmOe_reg || overheatAlarmNOe_reg)
    else $error("overheat not alarmed");
  chk_alarm_low: assert property (faultAlarmOe_reg |-> !faultAlarmOut_reg)
    else $error("alarm driven high");
  chk_alarm_split: assert property (!(faultAlarmOe_reg && (openLoopAlarmNOe_reg || overheatAlarmNOe_reg)))
    else $error("shared and strap alarms both active");
  chk_clear_force: assert property (clearIn[*4] |-> clearActive_reg)
    else $error("clear input ignored");
  chk_clear_mid: assert property (clearLevelSelPin[*4] |-> clearToMid_reg)
    else $error("clear level pin ignored");
  chk_cfg_hold: assert property (frameLong |-> $stable(rangeCode_reg) && $stable(outputOn_reg))
    else $error("configuration changed inside a frame");
endmodule // fsc_serial_port_chk

bind fsc_serial_port fsc_serial_port_chk fsc_serial_port_chk_inst (.*);
`default_nettype wire

/* File: tb/fsc_host_model.sv */
// Host serial controller model: sends frames MSB first, with CRC-8 when asked.
// Assumes the caller keeps frames apart; the serial clock stays high eight ref_clk cycles and low four.
`timescale 1ns/100ps
`default_nettype none

module fsc_host_model (
  input wire logic ref_clk,
  input wire logic sdo,
  input wire logic sdoOe,
  output var logic sclk,
  output var logic sdi,
  output var logic syncN
);
  // Idle state: strobe high and serial clock high.
  initial begin
    sclk = 1'b1;
    sdi = 1'b0;
    syncN = 1'b1;
  end

  // CRC-8 over one data word, zero start, most significant bit first.
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  // One frame; data changes while the clock is high so it is steady at the fall.
  // Readback bits are taken at falls 6 to 21; an undriven line reads as unknown.
  task automatic frame(input int n, input logic [23:0] w, output logic [15:0] rd);
    rd = 16'hxxxx;
    @(negedge ref_clk);
    syncN = 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (4) @(negedge ref_clk);
      sdi = w[n-1-i];
      repeat (4) @(negedge ref_clk);
      sclk = 1'b0;
      if (i > 4 && i < 21) rd[20-i] = sdoOe ? sdo : 1'bx;
      repeat (4) @(negedge ref_clk);
      sclk = 1'b1;
    end
    repeat (4) @(negedge ref_clk);
    syncN = 1'b1;
    sdi = ~sdi;
    repeat (8) @(negedge ref_clk);
  endtask
endmodule // fsc_host_model
`default_nettype wire

/* File: tb/fsc_serial_port_tb.sv */
// Self-checking bench for the fault, status and CRC serial port.
// Assumes the host model owns the serial pins; the bench drives straps and detectors.
`timescale 1ns/100ps
`default_nettype none

module fsc_serial_port_tb;
  logic ref_clk, rstn, serialClk, serialDataIn, frameSyncN, pinStrapModeSel, senseResSelPin;
  logic clearLevelSelPin, clearIn, overTempDetect, headroomLowDetect;
  logic [2:0] deviceAddrBits;
  logic [3:0] rangeCodePins, rangeCode_reg;
  logic serialDataOut_reg, serialDataOutOe_reg, faultAlarmOut_reg, faultAlarmOe_reg;
  logic openLoopAlarmNOut_reg, openLoopAlarmNOe_reg, overheatAlarmNOut_reg, overheatAlarmNOe_reg;
  logic senseResSel_reg, outputOn_reg, clearActive_reg, clearToMid_reg;
  logic [15:0] rd;
  int failCount = 0;
  int checked = 0;
  localparam logic [2:0] ADDR = 3'h5;

  fsc_serial_port fsc_serial_port_inst (.*);
  fsc_host_model fsc_host_model_inst (.ref_clk(ref_clk), .sdo(serialDataOut_reg),
    .sdoOe(serialDataOutOe_reg), .sclk(serialClk), .sdi(serialDataIn), .syncN(frameSyncN));

  // Free-running 250 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failCount++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Frame word: address, read bit, zero, range, {level, on, resistor, clear}.
  function automatic logic [15:0] word(input logic rw, input logic [3:0] r, input logic [3:0] c);
    return {ADDR, rw, 1'b0, r, c, 3'h0};
  endfunction

  task automatic send(input int n, input logic [15:0] w, input logic bad);
    fsc_host_model_inst.frame(n, n == 16 ? {8'h00, w} : {w, fsc_host_model_inst.crc8(w) ^ {7'h00, bad}}, rd);
  endtask

  task automatic doReset(input logic pin);
    tick(1);
    rstn = 1'b0;
    pinStrapModeSel = pin;
    tick(10);
    rstn = 1'b1;
    tick(4);
  endtask

  task automatic sc_write;
    cmp(outputOn_reg, 0, "on at reset");
    send(16, word(0, 4'ha, 4'b0110), 0);
    cmp(rangeCode_reg, 4'ha, "range");
    cmp({outputOn_reg, senseResSel_reg}, 2'b11, "on, resistor");
    send(16, word(0, 4'h1, 4'h0) ^ 16'h6000, 0);
    cmp(rangeCode_reg, 4'ha, "other address");
    send(20, word(0, 4'h1, 4'h0), 0);
    cmp(rangeCode_reg, 4'ha, "odd length");
  endtask

  task automatic sc_crc;
    send(24, word(0, 4'h3, 4'b0010), 1);
    cmp(rangeCode_reg, 4'ha, "bad crc kept");
    cmp({faultAlarmOe_reg, faultAlarmOut_reg}, 2'b10, "crc alarm");
    send(24, word(1, 4'h3, 4'b0010), 0);
    cmp(rd, {ADDR, 2'b10, 4'ha, 7'b0111000}, "readback crc");
    cmp({rangeCode_reg, senseResSel_reg}, 5'h07, "read applies");
    cmp({faultAlarmOe_reg, serialDataOutOe_reg}, 2'b00, "after read");
  endtask

  task automatic sc_detect;
    overTempDetect = 1'b1;
    tick(4);
    cmp(faultAlarmOe_reg, 1, "heat alarm");
    send(24, word(1, 4'h3, 4'b0010), 0);
    cmp(rd, {ADDR, 2'b10, 4'h3, 7'b0010100}, "readback heat");
    overTempDetect = 1'b0;
    headroomLowDetect = 1'b1;
    send(24, word(1, 4'h3, 4'b0010), 0);
    cmp(rd, {ADDR, 2'b10, 4'h3, 7'b0010010}, "readback loop");
    headroomLowDetect = 1'b0;
    tick(4);
    cmp(faultAlarmOe_reg, 0, "alarm released");
  endtask

  task automatic sc_clear;
    clearIn = 1'b1;
    tick(4);
    cmp({clearActive_reg, clearToMid_reg}, 2'b10, "clear bottom");
    clearLevelSelPin = 1'b1;
    tick(4);
    cmp(clearToMid_reg, 1, "clear pin mid");
    clearIn = 1'b0;
    clearLevelSelPin = 1'b0;
    tick(4);
    cmp(clearActive_reg, 0, "clear released");
    send(16, word(0, 4'h3, 4'b1011), 0);
    cmp({clearActive_reg, clearToMid_reg}, 2'b11, "soft clear mid");
    send(16, word(0, 4'h3, 4'b0010), 0);
    cmp({clearActive_reg, clearToMid_reg}, 2'b00, "soft clear off");
  endtask

  task automatic sc_pin;
    rangeCodePins = 4'hc;
    senseResSelPin = 1'b1;
    doReset(1);
    cmp({rangeCode_reg, senseResSel_reg, outputOn_reg}, 6'h33, "strap config");
    headroomLowDetect = 1'b1;
    tick(4);
    cmp({openLoopAlarmNOe_reg, openLoopAlarmNOut_reg, faultAlarmOe_reg}, 3'b100, "strap loop");
    headroomLowDetect = 1'b0;
    overTempDetect = 1'b1;
    tick(4);
    cmp({overheatAlarmNOe_reg, overheatAlarmNOut_reg}, 2'b10, "strap heat");
    send(24, word(1, 4'h3, 4'b0010), 0);
    cmp(rd, 16'hxxxx, "strap no read");
    cmp(rangeCode_reg, 4'hc, "strap range kept");
  endtask

  // Time-zero values, then the scenarios in order.
  initial begin
    rstn = 1'b0;
    pinStrapModeSel = 1'b0;
    deviceAddrBits = ADDR;
    rangeCodePins = 4'h0;
    senseResSelPin = 1'b0;
    clearLevelSelPin = 1'b0;
    clearIn = 1'b0;
    overTempDetect = 1'b0;
    headroomLowDetect = 1'b0;
    doReset(0);
    sc_write();
    sc_crc();
    sc_detect();
    sc_clear();
    sc_pin();
    summarize();
  end

  // Watchdog against a hung run.
  initial begin
    #200000;
    failCount++;
    summarize();
  end
endmodule // fsc_serial_port_tb
`default_nettype wire
